/* File: vapm_pkg.sv */
`default_nettype none
package vapm_pkg;
	// ---------------------------------------------------------------
	// host port addresses
	// ---------------------------------------------------------------
	localparam logic [15:0] PORT_ATTR_WR   = 16'h03C0;
	localparam logic [15:0] PORT_ATTR_RD   = 16'h03C1;
	localparam logic [15:0] PORT_STAT_MONO = 16'h03BA;
	localparam logic [15:0] PORT_STAT_COLR = 16'h03DA;
	// ---------------------------------------------------------------
	// register indexes and stored-bit masks
	// ---------------------------------------------------------------
	localparam logic [4:0] IDX_LAST_ENTRY = 5'h0F;
	localparam logic [4:0] IDX_MODE       = 5'h10;
	localparam logic [4:0] IDX_BORDER     = 5'h11;
	localparam logic [4:0] IDX_PLANE      = 5'h12;
	localparam logic [4:0] IDX_PAN        = 5'h13;
	localparam logic [4:0] IDX_CSEL       = 5'h14;
	localparam logic [7:0] MASK_INDEX     = 8'h3F;
	localparam logic [7:0] MASK_ENTRY     = 8'h3F;
	localparam logic [7:0] MASK_MODE      = 8'hEF;
	localparam logic [7:0] MASK_PLANE     = 8'h3F;
	localparam logic [7:0] MASK_PAN       = 8'h0F;
	localparam logic [7:0] MASK_CSEL      = 8'h0F;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int IDX_VIDEO_EN    = 5;
	localparam int MODE_P54_SEL    = 7;
	localparam int MODE_PIX8       = 6;
	localparam int MODE_PAN_COMPAT = 5;
	localparam int MODE_BLINK      = 3;
	localparam int MODE_LINE_GR    = 2;
	localparam int MODE_MONO       = 1;
	localparam int MODE_GRAPH      = 0;
	localparam int STAT_VSYNC      = 3;
	// ---------------------------------------------------------------
	// text decode and panning figures
	// ---------------------------------------------------------------
	localparam logic [7:0] LINE_CHAR_LO = 8'hB0;
	localparam logic [7:0] LINE_CHAR_HI = 8'hDF;
	localparam logic [2:0] MONO_INVERSE = 3'h7;
	localparam logic [2:0] MONO_ULINE   = 3'h1;
	localparam logic [2:0] MONO_DARK    = 3'h0;
	localparam logic [2:0] MONO_LIT     = 3'h7;
	localparam int         PAN_DEPTH    = 10;
	localparam logic [3:0] PAN_TAP_MAX  = 4'h9;
	localparam logic [3:0] PAN_ONE      = 4'h1;
	localparam logic [3:0] PAN_ZERO     = 4'h0;
endpackage
`default_nettype wire

/* File: vapm_delay.sv */
`timescale 1ns/1ps
`default_nettype none
// fixed-length delay line with a selectable tap; tap 0 is the newest entry
module vapm_delay #(
	parameter int W = 4,
	parameter int D = 10
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_n_in,
	input  wire logic         ce_in,
	input  wire logic         en_in,
	input  wire logic [W-1:0] d_in,
	input  wire logic [3:0]   tap_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [D-1:0][W-1:0] line;
	} vapm_delay_state_type;

	vapm_delay_state_type st_ff;
	vapm_delay_state_type nxt_st;

	// ---------------------------------------------------------------
	// shift on each dot
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (en_in) begin
			nxt_st.line = {st_ff.line[D-2:0], d_in};
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else if (ce_in) begin
			st_ff <= nxt_st;
		end
	end

	// tap beyond the line reads the oldest entry rather than an x
	assign q_out = (int'(tap_in) < D) ? st_ff.line[tap_in] : st_ff.line[D-1];
endmodule
`default_nettype wire

/* File: vapm_pack.sv */
`timescale 1ns/1ps
`default_nettype none
// joins two nibbles into one byte, first nibble high, strobe on the second
module vapm_pack (
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	input  wire logic       en_in,
	input  wire logic [3:0] nib_in,
	output logic      [7:0] byte_out,
	output logic            strobe_out
);
	typedef struct packed {
		logic       phase;
		logic [3:0] hi;
	} vapm_pack_state_type;

	vapm_pack_state_type st_ff;
	vapm_pack_state_type nxt_st;

	// ---------------------------------------------------------------
	// phase restarts whenever packing is off, so each line starts high
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (!en_in) begin
			nxt_st.phase = 1'b0;
		end else begin
			nxt_st.phase = ~st_ff.phase;
			if (!st_ff.phase) begin
				nxt_st.hi = nib_in;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else if (ce_in) begin
			st_ff <= nxt_st;
		end
	end

	assign byte_out   = {st_ff.hi, nib_in};
	assign strobe_out = en_in & st_ff.phase;
endmodule
`default_nettype wire

/* File: vapm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module vapm_top (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	input  wire logic        io_wr_in,
	input  wire logic        io_rd_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic [7:0]  io_wdata_in,
	output logic      [7:0]  io_rdata_out,
	input  wire logic        pix_valid_in,
	input  wire logic [3:0]  planes_in,
	input  wire logic [7:0]  attr_in,
	input  wire logic [7:0]  char_code_in,
	input  wire logic        glyph_in,
	input  wire logic        col9_in,
	input  wire logic        dot9_in,
	input  wire logic        underline_in,
	input  wire logic        blank_in,
	input  wire logic        lower_region_in,
	input  wire logic        vsync_in,
	input  wire logic [7:0]  blink_rate_in,
	output logic      [7:0]  pix_out,
	output logic             pix_valid_out
);
	typedef struct packed {
		logic             toggle;
		logic [5:0]       index;
		logic [15:0][5:0] entry;
		logic [7:0]       mode;
		logic [7:0]       border;
		logic [7:0]       plane;
		logic [7:0]       pan;
		logic [7:0]       csel;
		logic [7:0]       rdata;
		logic [7:0]       pix;
		logic             pix_valid;
		logic [7:0]       last_idx;
		logic             last_glyph;
		logic [7:0]       blink_cnt;
		logic             blink_ph;
		logic             vs_q;
	} vapm_state_type;

	vapm_state_type st_ff;
	vapm_state_type nxt_st;

	logic       wr_attr;
	logic       rd_data;
	logic       rd_stat;
	logic       vid_en;
	logic [4:0] idx;
	logic [7:0] data_rd;
	logic [1:0] stat_bits;
	logic       blink_off;
	logic       glyph;
	logic       mono_on;
	logic       mono_inv;
	logic [3:0] tnib;
	logic [3:0] mnib;
	logic [3:0] gnib;
	logic [3:0] nib;
	logic [3:0] shift;
	logic [3:0] tap;
	logic [3:0] nib_d;
	logic       blank_d;
	logic [7:0] pack_byte;
	logic       pack_strobe;
	logic [7:0] lut_idx;
	logic [5:0] ent;

	// ---------------------------------------------------------------
	// host port decode
	// ---------------------------------------------------------------
	assign wr_attr = io_wr_in && (io_addr_in == vapm_pkg::PORT_ATTR_WR);
	assign rd_data = io_rd_in && (io_addr_in == vapm_pkg::PORT_ATTR_RD);
	assign rd_stat = io_rd_in && ((io_addr_in == vapm_pkg::PORT_STAT_MONO) ||
		(io_addr_in == vapm_pkg::PORT_STAT_COLR));
	assign vid_en  = st_ff.index[vapm_pkg::IDX_VIDEO_EN];
	assign idx     = st_ff.index[4:0];

	// data port read mux; entries read as zero while video owns them
	always_comb begin
		data_rd = 8'h00;
		if (idx <= vapm_pkg::IDX_LAST_ENTRY) begin
			if (!vid_en) begin
				data_rd = {2'h0, st_ff.entry[idx[3:0]]};
			end
		end else begin
			case (idx)
				vapm_pkg::IDX_MODE:   data_rd = st_ff.mode;
				vapm_pkg::IDX_BORDER: data_rd = st_ff.border;
				vapm_pkg::IDX_PLANE:  data_rd = st_ff.plane;
				vapm_pkg::IDX_PAN:    data_rd = st_ff.pan;
				vapm_pkg::IDX_CSEL:   data_rd = st_ff.csel;
				default:              data_rd = 8'h00;
			endcase
		end
	end

	// status pair chosen from the last index sent out
	always_comb begin
		case (st_ff.plane[5:4])
			2'h0:    stat_bits = {st_ff.last_idx[2], st_ff.last_idx[0]};
			2'h1:    stat_bits = {st_ff.last_idx[5], st_ff.last_idx[4]};
			2'h2:    stat_bits = {st_ff.last_idx[3], st_ff.last_idx[1]};
			default: stat_bits = {st_ff.last_idx[7], st_ff.last_idx[6]};
		endcase
	end

	// ---------------------------------------------------------------
	// pixel value before panning
	// ---------------------------------------------------------------
	// ninth column only lights for line characters, so box glyphs join up
	always_comb begin
		glyph = glyph_in;
		if (col9_in) begin
			glyph = st_ff.mode[vapm_pkg::MODE_LINE_GR] &&
				(char_code_in >= vapm_pkg::LINE_CHAR_LO) &&
				(char_code_in <= vapm_pkg::LINE_CHAR_HI) && st_ff.last_glyph;
		end
	end

	assign blink_off = st_ff.mode[vapm_pkg::MODE_BLINK] & st_ff.blink_ph;
	// colour text: attribute bit 7 is blink or background intensity
	assign tnib = (glyph && !(blink_off && attr_in[7])) ? attr_in[3:0] :
		{attr_in[7] & ~st_ff.mode[vapm_pkg::MODE_BLINK], attr_in[6:4]};
	// monochrome text: underline, reverse video, intensity and blink only
	assign mono_on  = (glyph || (underline_in && attr_in[2:0] == vapm_pkg::MONO_ULINE)) &&
		!(blink_off && attr_in[7]);
	assign mono_inv = (attr_in[6:4] == vapm_pkg::MONO_INVERSE) &&
		(attr_in[2:0] == vapm_pkg::MONO_DARK);
	assign mnib = (mono_on ^ mono_inv) ? {attr_in[3], vapm_pkg::MONO_LIT} : 4'h0;
	// graphics blink flips the top plane bit off during the dark phase
	assign gnib = {planes_in[3] & ~blink_off, planes_in[2:0]};

	always_comb begin
		if (st_ff.mode[vapm_pkg::MODE_GRAPH]) begin
			nib = gnib;
		end else if (st_ff.mode[vapm_pkg::MODE_MONO]) begin
			nib = mnib;
		end else begin
			nib = tnib;
		end
		nib = nib & st_ff.plane[3:0];
	end

	// ---------------------------------------------------------------
	// horizontal panning
	// ---------------------------------------------------------------
	// a pan change mid-line tears the line; software changes it in blanking
	always_comb begin
		if (lower_region_in && st_ff.mode[vapm_pkg::MODE_PAN_COMPAT]) begin
			shift = vapm_pkg::PAN_ZERO;
		end else if (st_ff.mode[vapm_pkg::MODE_PIX8]) begin
			shift = {st_ff.pan[3:1], 1'b0};
		end else if (!st_ff.mode[vapm_pkg::MODE_GRAPH] && dot9_in) begin
			shift = st_ff.pan[3] ? vapm_pkg::PAN_ZERO :
				(st_ff.pan[3:0] + vapm_pkg::PAN_ONE);
		end else begin
			shift = {1'b0, st_ff.pan[2:0]};
		end
	end

	// in packed mode one shifted byte is two nibbles, hence the even nibble shift
	assign tap = vapm_pkg::PAN_TAP_MAX - shift;

	vapm_delay #(
		.W(4),
		.D(vapm_pkg::PAN_DEPTH)
	) u_pan_line (
		.mclk_in (mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in   (ce_in),
		.en_in   (pix_valid_in),
		.d_in    (nib),
		.tap_in  (tap),
		.q_out   (nib_d)
	);

	// blanking keeps its place on screen whatever the pan
	vapm_delay #(
		.W(1),
		.D(vapm_pkg::PAN_DEPTH)
	) u_blank_line (
		.mclk_in (mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in   (ce_in),
		.en_in   (pix_valid_in),
		.d_in    (blank_in),
		.tap_in  (vapm_pkg::PAN_TAP_MAX),
		.q_out   (blank_d)
	);

	vapm_pack u_pack (
		.mclk_in   (mclk_in),
		.rst_n_in  (rst_n_in),
		.ce_in     (ce_in),
		.en_in     (pix_valid_in & st_ff.mode[vapm_pkg::MODE_PIX8]),
		.nib_in    (nib_d),
		.byte_out  (pack_byte),
		.strobe_out(pack_strobe)
	);

	// ---------------------------------------------------------------
	// lookup into the eight-bit palette index
	// ---------------------------------------------------------------
	assign ent     = st_ff.entry[nib_d];
	assign lut_idx = {st_ff.csel[3:2],
		st_ff.mode[vapm_pkg::MODE_P54_SEL] ? st_ff.csel[1:0] : ent[5:4],
		ent[3:0]};

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.vs_q  = vsync_in;
		nxt_st.rdata = 8'h00;
		// blink phase flips once every blink_rate_in plus one rising sync edges
		if (vsync_in && !st_ff.vs_q) begin
			if (st_ff.blink_cnt >= blink_rate_in) begin
				nxt_st.blink_cnt = 8'h00;
				nxt_st.blink_ph  = ~st_ff.blink_ph;
			end else begin
				nxt_st.blink_cnt = st_ff.blink_cnt + 8'h01;
			end
		end
		// host writes: one toggle steers index or data
		if (wr_attr) begin
			nxt_st.toggle = ~st_ff.toggle;
			if (!st_ff.toggle) begin
				nxt_st.index = io_wdata_in[5:0] & vapm_pkg::MASK_INDEX[5:0];
			end else if (idx <= vapm_pkg::IDX_LAST_ENTRY) begin
				if (!vid_en) begin
					nxt_st.entry[idx[3:0]] = io_wdata_in[5:0] & vapm_pkg::MASK_ENTRY[5:0];
				end
			end else begin
				case (idx)
					vapm_pkg::IDX_MODE:   nxt_st.mode   = io_wdata_in & vapm_pkg::MASK_MODE;
					vapm_pkg::IDX_BORDER: nxt_st.border = io_wdata_in;
					vapm_pkg::IDX_PLANE:  nxt_st.plane  = io_wdata_in & vapm_pkg::MASK_PLANE;
					vapm_pkg::IDX_PAN:    nxt_st.pan    = io_wdata_in & vapm_pkg::MASK_PAN;
					vapm_pkg::IDX_CSEL:   nxt_st.csel   = io_wdata_in & vapm_pkg::MASK_CSEL;
					default:              nxt_st.csel   = st_ff.csel;
				endcase
			end
		end
		// host reads; the data port leaves the toggle alone
		if (io_rd_in && io_addr_in == vapm_pkg::PORT_ATTR_WR) begin
			nxt_st.rdata = {2'h0, st_ff.index};
		end else if (rd_data) begin
			nxt_st.rdata = data_rd;
		end else if (rd_stat) begin
			nxt_st.toggle = 1'b0;
			nxt_st.rdata  = {2'h0, stat_bits, 4'h0};
			nxt_st.rdata[vapm_pkg::STAT_VSYNC] = st_ff.vs_q;
		end
		// pixel out
		nxt_st.pix_valid = pix_valid_in &&
			(!st_ff.mode[vapm_pkg::MODE_PIX8] || pack_strobe);
		if (pix_valid_in) begin
			nxt_st.last_glyph = glyph_in;
			if (blank_d) begin
				nxt_st.pix = st_ff.border;
			end else if (st_ff.mode[vapm_pkg::MODE_PIX8]) begin
				nxt_st.pix = pack_byte;
			end else begin
				nxt_st.pix = lut_idx;
			end
			if (nxt_st.pix_valid) begin
				nxt_st.last_idx = nxt_st.pix;
			end
		end
	end

	// everything clears on reset; clock enable freezes all state
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else if (ce_in) begin
			st_ff <= nxt_st;
		end
	end

	assign io_rdata_out  = st_ff.rdata;
	assign pix_out       = st_ff.pix;
	assign pix_valid_out = st_ff.pix_valid;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	toggle_flip_a: assert property (ce_in && wr_attr
		|=> st_ff.toggle != $past(st_ff.toggle))
		else $error("toggle did not flip on a port write");
	data_read_keep_a: assert property (ce_in && rd_data && !io_wr_in
		|=> $stable(st_ff.toggle))
		else $error("data read moved the toggle");
	status_clear_a: assert property (ce_in && rd_stat && !io_wr_in |=> !st_ff.toggle)
		else $error("status read left toggle set");
	index_load_a: assert property (ce_in && wr_attr && !st_ff.toggle
		|=> st_ff.index == $past(io_wdata_in[5:0]))
		else $error("index not loaded");
	entry_lock_a: assert property (vid_en && !(ce_in && wr_attr && !st_ff.toggle)
		|=> $stable(st_ff.entry))
		else $error("entry changed while video enabled");
	border_out_a: assert property (ce_in && pix_valid_in && blank_d
		|=> pix_out == $past(st_ff.border))
		else $error("border colour not shown in blanking");
	upper_bits_a: assert property (ce_in && pix_valid_in && !blank_d
		&& !st_ff.mode[vapm_pkg::MODE_PIX8] |=> pix_out[7:6] == $past(st_ff.csel[3:2]))
		else $error("upper index bits not from colour select");
	pack_rate_a: assert property (ce_in && st_ff.mode[vapm_pkg::MODE_PIX8] && pix_valid_out
		&& $stable(st_ff.mode) |=> !pix_valid_out)
		else $error("packed bytes on consecutive dots");
	status_mux_a: assert property (ce_in && rd_stat && !io_wr_in && st_ff.plane[5:4] == 2'h3
		|=> io_rdata_out[5:4] == $past(st_ff.last_idx[7:6]))
		else $error("status bits wrong");
	reset_clear_a: assert property ($rose(rst_n_in) |-> st_ff.mode == 8'h00 && !st_ff.toggle)
		else $error("registers not cleared by reset");
endmodule
`default_nettype wire

/* File: vapm_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none
// sequencer feed: one dot a cycle while enabled, a running count on planes
// and on the attribute foreground nibble so every dot is told apart
module vapm_seq_model (
	input  wire logic       mclk_in,
	input  wire logic       en_in,
	input  wire logic       glyph_val_in,
	input  wire logic [3:0] attr_hi_in,
	output logic            pix_valid_out,
	output logic      [3:0] planes_out,
	output logic      [7:0] attr_out,
	output logic            glyph_out
);
	// ----
	// dot source
	// ----
	// outside dots the plane and attribute lines invert on every cycle, so a stale value never
	// passes for a real dot
	initial begin
		pix_valid_out = 1'b0;
		planes_out    = 4'h0;
		attr_out      = 8'h00;
		glyph_out     = 1'b0;
	end
	always @(negedge mclk_in) begin
		pix_valid_out <= en_in;
		glyph_out     <= glyph_val_in;
		if (en_in) begin
			planes_out <= planes_out + 4'h1;
			attr_out   <= {attr_hi_in, planes_out + 4'h1};
		end else begin
			planes_out <= ~planes_out;
			attr_out   <= ~attr_out;
		end
	end
endmodule
`default_nettype wire

/* File: vga_attribute_pixel_mapper_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module vga_attribute_pixel_mapper_tb;
	// ----
	// signals
	// ----
	logic        mclk_in  = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        io_wr    = 1'b0;
	logic        io_rd    = 1'b0;
	logic [15:0] io_addr  = 16'h0000;
	logic [7:0]  io_wdata = 8'h00;
	logic        dot9     = 1'b0;
	logic        blank    = 1'b0;
	logic        lower    = 1'b0;
	logic        vsync    = 1'b0;
	logic        col9     = 1'b0;
	logic        uline    = 1'b0;
	logic [7:0]  code     = 8'h00;
	logic        seq_en   = 1'b0;
	logic        seq_gl   = 1'b1;
	logic [3:0]  seq_hi   = 4'h0;
	logic        pv;
	logic [3:0]  planes;
	logic [7:0]  attr;
	logic        glyph;
	logic [7:0]  rdata;
	logic [7:0]  pix;
	logic        pix_vld;
	int          fails      = 0;
	int          num_checks = 0;
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] pan;
		logic [7:0] csel;
		logic [7:0] plane;
		logic       dot9;
		logic       lower;
		logic [3:0] shift;
	} vapm_row_type;
	// mode, pan, colour select, plane enable, 9-dot, lower region, dots shifted
	vapm_row_type rows [10] = '{
		'{8'h01, 8'h00, 8'h00, 8'h0F, 1'b0, 1'b0, 4'h0},
		'{8'h01, 8'h03, 8'h0C, 8'h1F, 1'b0, 1'b0, 4'h3},
		'{8'h81, 8'h07, 8'h06, 8'h2F, 1'b0, 1'b0, 4'h7},
		'{8'h01, 8'h05, 8'h00, 8'h35, 1'b0, 1'b0, 4'h5},
		'{8'h00, 8'h00, 8'h00, 8'h0F, 1'b1, 1'b0, 4'h1},
		'{8'h00, 8'h07, 8'h00, 8'h1F, 1'b1, 1'b0, 4'h8},
		'{8'h00, 8'h08, 8'h00, 8'h2F, 1'b1, 1'b0, 4'h0},
		'{8'h00, 8'h02, 8'h00, 8'h3F, 1'b0, 1'b0, 4'h2},
		'{8'h21, 8'h04, 8'h00, 8'h0F, 1'b0, 1'b1, 4'h0},
		'{8'h01, 8'h04, 8'h00, 8'h1F, 1'b0, 1'b1, 4'h4}
	};
	logic [7:0]  pk_pan [3] = '{8'h00, 8'h02, 8'h06};
	always #5 mclk_in = ~mclk_in;
	// ----
	// design and far side
	// ----
	vapm_top u_dut (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
		.io_wr_in(io_wr), .io_rd_in(io_rd), .io_addr_in(io_addr),
		.io_wdata_in(io_wdata), .io_rdata_out(rdata), .pix_valid_in(pv),
		.planes_in(planes), .attr_in(attr), .char_code_in(code),
		.glyph_in(glyph), .col9_in(col9), .dot9_in(dot9), .underline_in(uline),
		.blank_in(blank), .lower_region_in(lower), .vsync_in(vsync),
		.blink_rate_in(8'h00), .pix_out(pix), .pix_valid_out(pix_vld)
	);
	vapm_seq_model u_seq (
		.mclk_in(mclk_in), .en_in(seq_en), .glyph_val_in(seq_gl),
		.attr_hi_in(seq_hi), .pix_valid_out(pv), .planes_out(planes),
		.attr_out(attr), .glyph_out(glyph)
	);
	// ----
	// helpers
	// ----
	function automatic logic [7:0] lut(input logic [3:0] m, input logic [7:0] md,
		input logic [7:0] cs);
		lut = {cs[3:2], md[7] ? cs[1:0] : m[1:0], m};
	endfunction
	function automatic logic [7:0] stat(input logic [7:0] p, input logic [1:0] s);
		case (s)
			2'h0: stat = {2'h0, p[2], p[0], 4'h0};
			2'h1: stat = {2'h0, p[5], p[4], 4'h0};
			2'h2: stat = {2'h0, p[3], p[1], 4'h0};
			default: stat = {2'h0, p[7], p[6], 4'h0};
		endcase
	endfunction
	function automatic logic [7:0] rmask(input int i);
		case (i)
			16: rmask = vapm_pkg::MASK_MODE;
			17: rmask = 8'hFF;
			18: rmask = vapm_pkg::MASK_PLANE;
			19: rmask = vapm_pkg::MASK_PAN;
			20: rmask = vapm_pkg::MASK_CSEL;
			default: rmask = vapm_pkg::MASK_ENTRY;
		endcase
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// host strobes rise and fall on falling edges, one idle cycle between
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk_in);
		io_addr  = a;
		io_wdata = d;
		io_wr    = 1'b1;
		@(negedge mclk_in);
		io_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge mclk_in);
		io_addr = a;
		io_rd   = 1'b1;
		@(negedge mclk_in);
		d     = rdata;
		io_rd = 1'b0;
	endtask
	// a status read first puts the toggle at index loading whatever came before
	task automatic wreg(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] s;
		rd(vapm_pkg::PORT_STAT_COLR, s);
		wr(vapm_pkg::PORT_ATTR_WR, i);
		wr(vapm_pkg::PORT_ATTR_WR, d);
	endtask
	task automatic rreg(input logic [7:0] i, output logic [7:0] d);
		logic [7:0] s;
		rd(vapm_pkg::PORT_STAT_COLR, s);
		wr(vapm_pkg::PORT_ATTR_WR, i);
		rd(vapm_pkg::PORT_ATTR_RD, d);
	endtask
	// far-side controls move just after a rising edge, clear of its falling-edge driver
	task automatic after_rise(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ----
	// tests
	// ----
	initial begin
		vapm_row_type r;
		logic [7:0]   d;
		logic [7:0]   e;
		logic [3:0]   v;
		int           k;
		repeat (2) @(negedge mclk_in);
		rst_n_in = 1'b1;
		// entries hold {value[1:0], value} so each index bit can be traced
		for (int n = 0; n < 16; n++) begin
			wreg(8'(n), {2'b00, 2'(n), 4'(n)});
		end
		foreach (rows[i]) begin
			r = rows[i];
			wreg(8'h10, r.mode);
			wreg(8'h12, r.plane);
			wreg(8'h13, r.pan);
			wreg(8'h14, r.csel);
			@(negedge mclk_in);
			dot9  = r.dot9;
			lower = r.lower;
			after_rise(1);
			seq_en = 1'b1;
			after_rise(16);
			for (k = 0; k < 4; k++) begin
				after_rise(1);
				v = planes + r.shift + 4'h6;
				e = lut(v & r.plane[3:0], r.mode, r.csel);
				check(pix, e);
				check({7'h00, pix_vld}, 8'h01);
			end
			seq_en = 1'b0;
			rd(vapm_pkg::PORT_STAT_COLR, d);
			check(d, stat(e, r.plane[5:4]));
			$display("row %0d done", i);
		end
		// packed bytes: pan counts nibbles; the host keeps pan bit 0 clear
		wreg(8'h12, 8'h0F);
		wreg(8'h10, 8'h41);
		for (int j = 0; j < 3; j++) begin
			wreg(8'h13, pk_pan[j]);
			after_rise(1);
			seq_en = 1'b1;
			after_rise(16);
			k = 0;
			repeat (8) begin
				after_rise(1);
				if (pix_vld === 1'b1) begin
					k++;
					v = planes + (pk_pan[j][3:0] & 4'hE) + 4'h6;
					check(pix, {v - 4'h1, v});
				end
			end
			check(8'(k), 8'h04);
			seq_en = 1'b0;
		end
		$display("packed pixel test done");
		wreg(8'h10, 8'h00);
		wreg(8'h11, 8'hA5);
		@(negedge mclk_in);
		blank = 1'b1;
		after_rise(1);
		seq_en = 1'b1;
		after_rise(14);
		check(pix, 8'hA5);
		@(negedge mclk_in);
		blank = 1'b0;
		after_rise(1);
		seq_gl = 1'b0;
		seq_hi = 4'h8;
		after_rise(16);
		check(pix, 8'h08);
		wreg(8'h10, 8'h08);
		after_rise(16);
		check(pix, 8'h00);
		seq_gl = 1'b1;
		@(negedge mclk_in);
		vsync = 1'b1;
		@(negedge mclk_in);
		vsync = 1'b0;
		after_rise(16);
		check(pix, 8'h00);
		after_rise(1);
		check(pix, 8'h00);
		// ninth column: line characters repeat the eighth dot, others get background
		wreg(8'h13, 8'h00);
		wreg(8'h10, 8'h04);
		after_rise(1);
		seq_hi = 4'h0;
		@(negedge mclk_in);
		col9 = 1'b1;
		code = 8'hC4;
		after_rise(16);
		v = planes + 4'h6;
		check(pix, lut(v, 8'h04, 8'h00));
		@(negedge mclk_in);
		code = 8'h41;
		after_rise(16);
		check(pix, 8'h00);
		@(negedge mclk_in);
		col9 = 1'b0;
		// monochrome decode: a lit dot is the intensity bit over 111
		wreg(8'h11, 8'h00);
		wreg(8'h10, 8'h02);
		after_rise(16);
		v = planes + 4'h6;
		check(pix, lut({v[3], 3'h7}, 8'h02, 8'h00));
		after_rise(1);
		seq_gl = 1'b0;
		@(negedge mclk_in);
		uline = 1'b1;
		after_rise(16);
		// eight dots so at least one carries the underline attribute
		for (k = 0; k < 8; k++) begin
			after_rise(1);
			v = planes + 4'h6;
			e = (v[2:0] == 3'h1) ? lut({v[3], 3'h7}, 8'h02, 8'h00) : 8'h00;
			check(pix, e);
		end
		seq_en = 1'b0;
		$display("border and blink test done");
		for (int i = 0; i <= 20; i++) begin
			wreg(8'(i), 8'hFF);
			rreg(8'(i), d);
			check(d, rmask(i));
		end
		wreg(8'h23, 8'h11);
		rreg(8'h23, d);
		check(d, 8'h00);
		rreg(8'h03, d);
		check(d, 8'h3F);
		wreg(8'h15, 8'hAA);
		rreg(8'h15, d);
		check(d, 8'h00);
		rd(vapm_pkg::PORT_STAT_COLR, d);
		wr(vapm_pkg::PORT_ATTR_WR, 8'h10);
		rd(vapm_pkg::PORT_ATTR_RD, d);
		wr(vapm_pkg::PORT_ATTR_WR, 8'h03);
		rreg(8'h10, d);
		check(d, 8'h03);
		rd(vapm_pkg::PORT_STAT_COLR, d);
		wr(vapm_pkg::PORT_ATTR_WR, 8'h11);
		rd(vapm_pkg::PORT_STAT_COLR, d);
		wr(vapm_pkg::PORT_ATTR_WR, 8'h12);
		rd(vapm_pkg::PORT_ATTR_WR, d);
		check(d, 8'h12);
		$display("register port test done");
		@(negedge mclk_in);
		rst_n_in = 1'b0;
		repeat (2) @(negedge mclk_in);
		rst_n_in = 1'b1;
		check(pix, 8'h00);
		rd(vapm_pkg::PORT_ATTR_WR, d);
		check(d, 8'h00);
		for (int i = 0; i <= 20; i++) begin
			rreg(8'(i), d);
			check(d, 8'h00);
		end
		$display("reset test done");
		summarize();
	end
	// the whole run needs about 1300 cycles
	initial begin
		repeat (20000) @(posedge mclk_in);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
